// *** pdc_pin_conditioning.sv ***
// Deglitch, gating, multiplexing and output drive of the supervisor's digital pins
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Error input filtered 15 us, pulled up
// - Alternative watchdog disable, filtered 30 us
// - Enable input filtered 8 us, pulled down
// - Enable works whenever supply is valid
// - Other inputs held until configuration read
// - Multipurpose input selects address, 8 us
// - Multipurpose pin as general output
// - Multipurpose pin as interrupt output
// - Monitor two pin as sync clock
// - Monitor deglitch time is programmable
// - Outputs open-drain/push-pull and either polarity
// - Open-drain pull-up only while output high
module pdc_pin_conditioning (
   input  wire  logic        clock,
   input  wire  logic        rstn,
   input  wire  logic        supplyValid,
   input  wire  logic        configLoaded,
   input  wire  logic        coreResetReq,
   input  wire  logic        coreIrqReq,
   input  wire  logic        enablePin,
   input  wire  logic        errorPin,
   input  wire  logic        monitorOnePin,
   input  wire  logic        monitorTwoPin,
   input  wire  logic        multiPinIn,
   output logic              enableLevel,
   output logic              errorLevel,
   output logic              watchdogDisable,
   output logic              monitorOneLevel,
   output logic              monitorTwoLevel,
   output logic              syncClockOut,
   output logic              busAddrSel,
   output logic              irq,
   output logic              resetPinOut,
   output logic              resetPinOeN,
   output logic              resetPinPullup,
   output logic              multiPinOut,
   output logic              multiPinOeN,
   output logic              multiPinPullup,
   input  wire  logic [4:0]  s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   input  wire  logic [4:0]  s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready
);
   import pdc_pkg::*;

   logic [4:0]      pinCtrl;
   logic [5:0]      outCfg;
   logic [3:0]      filtSel;
   logic [4:0]      evtStat;
   logic [4:0]      evtEn;
   logic [4:0]      syncA;
   logic [4:0]      syncB;
   logic [NFILT-1:0] filt;
   logic [NFILT-1:0] prevFilt;
   logic [NFILT-1:0] raw;
   logic [NFILT-1:0] run;
   logic [NFILT-1:0] filtRst;
   logic [CW-1:0]   flen [NFILT];
   logic            live;
   pdc_multi_e      multiMode;
   logic [4:0]      awAddr;
   logic [31:0]     wData;
   logic [3:0]      wStrb;
   logic            awHeld;
   logic            wHeld;
   logic            doWrite;
   logic [4:0]      clrMask;
   logic [4:0]      evtSet;
   logic            irqReqLevel;
   logic            gpoLevel;
   logic            rLvl;
   logic            mLvl;

   // Counters must hold the longest stable time, or a truncated length would make a filter accept early
   if (WD_DGL_US * CLK_MHZ >= 2 ** CW || MON_DGL3_US * CLK_MHZ >= 2 ** CW) begin : gWidthCheck
      $error("deglitch counter too narrow");
   end

   // Pin inputs come from the board, so two flops before any logic
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         syncA <= 5'h00;
         syncB <= 5'h00;
      end else begin
         syncA <= {multiPinIn, monitorTwoPin, monitorOnePin, errorPin, enablePin};
         syncB <= syncA;
      end
   end

   // Supply and config status come from core logic on this clock
   assign live      = supplyValid & configLoaded;
   assign multiMode = pdc_multi_e'(pinCtrl[MULTI_LSB +: 2]);

   // Filter slots: enable, error, watchdog disable, monitor one, monitor two, address
   assign raw     = {syncB[4], syncB[3], syncB[2], syncB[1], syncB[1], syncB[0]};
   assign filtRst = 6'h02;                           // Error input idles high through its pull-up
   assign run[0]  = supplyValid;
   assign run[1]  = live & ~pinCtrl[ERR_MODE_BIT];
   assign run[2]  = live & pinCtrl[ERR_MODE_BIT];
   assign run[3]  = live;
   assign run[4]  = live & ~pinCtrl[MON2_MODE_BIT];
   assign run[5]  = live & (multiMode == PDC_ADDR_IN);

   function automatic logic [CW-1:0] monLen(input logic [1:0] sel);
      case (sel)
         2'h0:    monLen = MON_CYC0;
         2'h1:    monLen = MON_CYC1;
         2'h2:    monLen = MON_CYC2;
         default: monLen = MON_CYC3;
      endcase
   endfunction

   // Stable-time lengths per slot; monitor lengths follow software selection
   always_comb begin
      flen[0] = EN_CYC;
      flen[1] = ERR_CYC;
      flen[2] = WD_CYC;
      flen[3] = monLen(filtSel[MON1_SEL_LSB +: 2]);
      flen[4] = monLen(filtSel[MON2_SEL_LSB +: 2]);
      flen[5] = ADDR_CYC;
   end

   // One deglitch counter per slot; any return to the old level restarts it
   for (genvar g = 0; g < NFILT; g++) begin : gFilt
      logic [CW-1:0] cnt;
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            cnt     <= '0;
            filt[g] <= (g == 1);
         end else if (!run[g]) begin
            cnt     <= '0;
            filt[g] <= filtRst[g];
         end else if (raw[g] == filt[g]) begin
            cnt <= '0;
         end else if (cnt == flen[g] - CW'(1)) begin
            cnt     <= '0;
            filt[g] <= raw[g];
         end else begin
            cnt <= cnt + CW'(1);
         end
      end
   end

   assign enableLevel     = filt[0];
   assign errorLevel      = filt[1];
   assign watchdogDisable = filt[2];
   assign monitorOneLevel = filt[3];
   assign monitorTwoLevel = filt[4];
   assign busAddrSel      = filt[5];

   // Sync clock has no deglitch: a filter would eat the clock itself
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         syncClockOut <= 1'b0;
      end else begin
         syncClockOut <= live & pinCtrl[MON2_MODE_BIT] & syncB[3];
      end
   end

   // Event flags on any change of a filtered level except the address select; set beats clear
   assign evtSet = filt[4:0] ^ prevFilt[4:0];
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prevFilt <= 6'h02;
         evtStat  <= 5'h00;
         irq      <= 1'b0;
      end else begin
         prevFilt <= filt;
         evtStat  <= (evtStat & ~clrMask) | evtSet;
         irq      <= |(evtStat & evtEn);
      end
   end

   // Output pin drive: polarity first, then open-drain or push-pull
   assign irqReqLevel = irq | coreIrqReq;
   assign gpoLevel    = (multiMode == PDC_GPO_OUT) ? pinCtrl[GPO_VAL_BIT] : irqReqLevel;
   assign rLvl        = outCfg[RST_CFG_LSB + AH_BIT] ? coreResetReq : ~coreResetReq;
   assign mLvl        = outCfg[IRQ_CFG_LSB + AH_BIT] ? gpoLevel : ~gpoLevel;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         resetPinOut    <= 1'b0;
         resetPinOeN    <= 1'b0;
         resetPinPullup <= 1'b0;
         multiPinOut    <= 1'b0;
         multiPinOeN    <= 1'b1;
         multiPinPullup <= 1'b0;
      end else begin
         if (outCfg[RST_CFG_LSB + OD_BIT]) begin
            resetPinOut    <= 1'b0;
            resetPinOeN    <= rLvl;
            resetPinPullup <= rLvl & outCfg[RST_CFG_LSB + PU_BIT];
         end else begin
            resetPinOut    <= rLvl;
            resetPinOeN    <= 1'b0;
            resetPinPullup <= 1'b0;
         end
         if (multiMode == PDC_ADDR_IN || multiMode > PDC_IRQ_OUT) begin
            multiPinOut    <= 1'b0;
            multiPinOeN    <= 1'b1;
            multiPinPullup <= 1'b0;
         end else if (outCfg[IRQ_CFG_LSB + OD_BIT]) begin
            multiPinOut    <= 1'b0;
            multiPinOeN    <= mLvl;
            multiPinPullup <= mLvl & outCfg[IRQ_CFG_LSB + PU_BIT];
         end else begin
            multiPinOut    <= mLvl;
            multiPinOeN    <= 1'b0;
            multiPinPullup <= 1'b0;
         end
      end
   end

   // Write channel: address and data taken in either order, held until both
   assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= 5'h00;
         wData         <= 32'h0000_0000;
         wStrb         <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= ~awHeld & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready  <= ~wHeld & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr[1:0] == 2'h0 && awAddr <= EVT_EN_OFS) ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register stores; all fields sit in byte lane 0
   assign clrMask = (doWrite && awAddr == EVT_CLR_OFS && wStrb[0]) ? wData[4:0] : 5'h00;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pinCtrl <= PIN_CTRL_RST;
         outCfg  <= OUT_CFG_RST;
         filtSel <= FILT_SEL_RST;
         evtEn   <= 5'h00;
      end else if (doWrite && wStrb[0]) begin
         unique case (awAddr)
            PIN_CTRL_OFS: pinCtrl <= wData[4:0];
            OUT_CFG_OFS:  outCfg  <= wData[5:0];
            FILT_SEL_OFS: filtSel <= wData[3:0];
            EVT_EN_OFS:   evtEn   <= wData[4:0];
            default:      ;
         endcase
      end
   end

   // Read channel: one read at a time, answer the cycle after acceptance
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
               PIN_CTRL_OFS: s_axi_rdata <= {27'h0, pinCtrl};
               OUT_CFG_OFS:  s_axi_rdata <= {26'h0, outCfg};
               FILT_SEL_OFS: s_axi_rdata <= {28'h0, filtSel};
               LEVELS_OFS:   s_axi_rdata <= {24'h0, live, syncClockOut, filt};
               EVT_STAT_OFS: s_axi_rdata <= {27'h0, evtStat};
               EVT_CLR_OFS:  s_axi_rdata <= 32'h0000_0000;
               EVT_EN_OFS:   s_axi_rdata <= {27'h0, evtEn};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks on filter timing, gating and pin drive
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_error_stable_time: assert property ($changed(filt[1]) && $past(run[1]) |->
      $past(gFilt[1].cnt) == ERR_CYC - CW'(1)) else $error("error input accepted early");
   a_watchdog_stable_time: assert property ($changed(filt[2]) && $past(run[2]) |->
      $past(gFilt[2].cnt) == WD_CYC - CW'(1)) else $error("watchdog disable accepted early");
   a_enable_stable_time: assert property ($changed(filt[0]) && supplyValid |->
      $past(gFilt[0].cnt) == EN_CYC - CW'(1)) else $error("enable accepted early");
   a_enable_runs_early: assert property (supplyValid && !configLoaded &&
      raw[0] != filt[0] && gFilt[0].cnt < EN_CYC - CW'(1) |=> gFilt[0].cnt != '0)
      else $error("enable filter stalled before config");
   a_inputs_held: assert property (!live |=> filt[5:1] == 5'h01)
      else $error("input live before config read");
   a_monitor_len: assert property ($changed(filt[3]) && $past(live) |->
      $past(gFilt[3].cnt) == $past(flen[3]) - CW'(1)) else $error("monitor one length wrong");
   a_addr_gated: assert property (multiMode != PDC_ADDR_IN |=> !busAddrSel)
      else $error("address select live in output mode");
   a_gpo_drive: assert property ($past(multiMode == PDC_GPO_OUT) && !$past(outCfg[IRQ_CFG_LSB + OD_BIT])
      |-> !multiPinOeN && multiPinOut == ($past(pinCtrl[GPO_VAL_BIT]) ~^ $past(outCfg[IRQ_CFG_LSB + AH_BIT])))
      else $error("general output level wrong");
   a_irq_pin: assert property (multiMode == PDC_IRQ_OUT && $stable(outCfg) && outCfg[IRQ_CFG_LSB + OD_BIT]
      && !outCfg[IRQ_CFG_LSB + AH_BIT] && irq |=> !multiPinOeN && !multiPinOut)
      else $error("interrupt not driven low");
   a_sync_pass: assert property (syncClockOut |-> $past(pinCtrl[MON2_MODE_BIT] && live))
      else $error("sync clock passed while not selected");
   a_pullup_low: assert property (!resetPinOeN && !resetPinOut |-> !resetPinPullup)
      else $error("reset pull-up on while low");
   a_pullup_multi: assert property (!multiPinOeN && !multiPinOut |-> !multiPinPullup)
      else $error("multipurpose pull-up on while low");

   c_error_change: cover property ($changed(filt[1]));
   c_irq_raise: cover property ($rose(irq));
   c_reg_write: cover property (doWrite);
endmodule
`default_nettype wire

// *** pdc_pkg.sv ***
// Constants, register map and mode codes for the digital pin conditioning block
package pdc_pkg;
   // Core clock rate and deglitch times
   localparam int CLK_MHZ      = 100;
   localparam int EN_DGL_US    = 8;
   localparam int ERR_DGL_US   = 15;
   localparam int WD_DGL_US    = 30;
   localparam int ADDR_DGL_US  = 8;
   localparam int MON_DGL0_US  = 4;
   localparam int MON_DGL1_US  = 8;
   localparam int MON_DGL2_US  = 16;
   localparam int MON_DGL3_US  = 32;
   localparam int CW           = 12;
   localparam logic [CW-1:0] EN_CYC   = CW'(EN_DGL_US * CLK_MHZ);
   localparam logic [CW-1:0] ERR_CYC  = CW'(ERR_DGL_US * CLK_MHZ);
   localparam logic [CW-1:0] WD_CYC   = CW'(WD_DGL_US * CLK_MHZ);
   localparam logic [CW-1:0] ADDR_CYC = CW'(ADDR_DGL_US * CLK_MHZ);
   localparam logic [CW-1:0] MON_CYC0 = CW'(MON_DGL0_US * CLK_MHZ);
   localparam logic [CW-1:0] MON_CYC1 = CW'(MON_DGL1_US * CLK_MHZ);
   localparam logic [CW-1:0] MON_CYC2 = CW'(MON_DGL2_US * CLK_MHZ);
   localparam logic [CW-1:0] MON_CYC3 = CW'(MON_DGL3_US * CLK_MHZ);
   // Register byte offsets
   localparam logic [4:0] PIN_CTRL_OFS   = 5'h00;
   localparam logic [4:0] OUT_CFG_OFS    = 5'h04;
   localparam logic [4:0] FILT_SEL_OFS   = 5'h08;
   localparam logic [4:0] LEVELS_OFS     = 5'h0C;
   localparam logic [4:0] EVT_STAT_OFS   = 5'h10;
   localparam logic [4:0] EVT_CLR_OFS    = 5'h14;
   localparam logic [4:0] EVT_EN_OFS     = 5'h18;
   // Pin control fields
   localparam int ERR_MODE_BIT  = 0;
   localparam int MON2_MODE_BIT = 1;
   localparam int MULTI_LSB     = 2;
   localparam int GPO_VAL_BIT   = 4;
   // Output config fields: open-drain, active-high, pull-up enable
   localparam int RST_CFG_LSB = 0;
   localparam int IRQ_CFG_LSB = 3;
   localparam int OD_BIT = 0;
   localparam int AH_BIT = 1;
   localparam int PU_BIT = 2;
   // Filter select fields
   localparam int MON1_SEL_LSB = 0;
   localparam int MON2_SEL_LSB = 2;
   // Reset values
   localparam logic [4:0] PIN_CTRL_RST = 5'h00;
   localparam logic [5:0] OUT_CFG_RST  = 6'h2D;
   localparam logic [3:0] FILT_SEL_RST = 4'h0;
   localparam int NFILT = 6;
   // Multipurpose pin modes
   typedef enum logic [1:0] {PDC_ADDR_IN, PDC_GPO_OUT, PDC_IRQ_OUT} pdc_multi_e;
endpackage

// *** pdc_board_model.sv ***
// Board model: host line resolution and the address strap of the pin block
`timescale 1ns/1ps
`default_nettype none
module pdc_board_model (
   input  wire logic strapHigh,
   input  wire logic resetPinOut,
   input  wire logic resetPinOeN,
   input  wire logic resetPinPullup,
   input  wire logic multiPinOut,
   input  wire logic multiPinOeN,
   input  wire logic multiPinPullup,
   output logic      resetWire,
   output logic      multiWire
);
   // Reset line has a weak board pull-down, so an undriven line with no pull-up reads low
   assign resetWire = !resetPinOeN ? resetPinOut : resetPinPullup;
   // Shared line: device driver first, then internal pull-up, then the strap resistor
   assign multiWire = !multiPinOeN ? multiPinOut : (multiPinPullup | strapHigh);
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the digital pin conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pdc_pkg::*;
   typedef struct {logic [4:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} pdc_row_s;
   logic        clock = 0, rstn = 0, supplyValid = 1, configLoaded = 0;
   logic        coreResetReq = 0, coreIrqReq = 0, strapHigh = 1;
   logic        enablePin = 0, errorPin = 1, monitorOnePin = 0, monitorTwoPin = 0;
   logic        enableLevel, errorLevel, watchdogDisable, monitorOneLevel, monitorTwoLevel;
   logic        syncClockOut, busAddrSel, irq, resetWire, multiPinIn, lev;
   logic        resetPinOut, resetPinOeN, resetPinPullup, multiPinOut, multiPinOeN, multiPinPullup;
   logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdVal;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [2:0]  exp3;
   int          failures = 0, total_checks = 0;
   // Register rows: address, written word, word read back, response of both
   pdc_row_s rows[8] = '{'{FILT_SEL_OFS, 32'h0000000F, 32'h0000000F, 2'h0},
      '{FILT_SEL_OFS, 32'h00000003, 32'h00000003, 2'h0}, '{EVT_EN_OFS, 32'h0000001F, 32'h0000001F, 2'h0},
      '{EVT_EN_OFS, 32'h00000000, 32'h00000000, 2'h0}, '{EVT_CLR_OFS, 32'h0000001F, 32'h00000000, 2'h0},
      '{5'h1C, 32'h0000005A, 32'h00000000, 2'h2}, '{5'h02, 32'h0000005A, 32'h00000000, 2'h2},
      '{OUT_CFG_OFS, 32'h0000002D, 32'h0000002D, 2'h0}};

   pdc_pin_conditioning DUT (.*);
   pdc_board_model board (.strapHigh(strapHigh), .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
      .resetPinPullup(resetPinPullup), .multiPinOut(multiPinOut), .multiPinOeN(multiPinOeN),
      .multiPinPullup(multiPinPullup), .resetWire(resetWire), .multiWire(multiPinIn));

   // Core clock, 100 MHz
   always #5 clock = ~clock;

   task automatic end_of_test;
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic hang;
      failures++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      end_of_test();
   endtask

   // Bus write: address and data offered together, each dropped once its ready is seen
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      bit done;
      done = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1;
         end
      end
      if (!done) hang();
   endtask

   task automatic rd_reg(input logic [4:0] a);
      bit done;
      done = 0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            resp = s_axi_rresp;
            rdVal = s_axi_rdata;
            s_axi_rready <= 1'b0;
            done = 1;
         end
      end
      if (!done) hang();
   endtask

   // Slot 4 is the address strap, slot 5 the watchdog view of the error pin
   task automatic setpin(input int i, input logic v);
      @(posedge clock);
      case (i)
         0: enablePin <= v;
         1, 5: errorPin <= v;
         2: monitorOnePin <= v;
         3: monitorTwoPin <= v;
         default: strapHigh <= v;
      endcase
   endtask

   function automatic logic lvl(input int i);
      logic [5:0] l;
      l = {watchdogDisable, busAddrSel, monitorTwoLevel, monitorOneLevel, errorLevel, enableLevel};
      return l[i];
   endfunction

   // Full-length change must pass a few cycles after n; a pulse 20 short must not pass
   task automatic filt(input int i, input logic v, input int n, input bit shrt);
      setpin(i, v);
      if (shrt) begin
         cyc(n - 20);
         setpin(i, !v);
         cyc(n + 10);
         chk(lvl(i), !v, "short pulse passed");
      end else begin
         cyc(n);
         chk(lvl(i), !v, "filter too early");
         cyc(8);
         chk(lvl(i), v, "filter too late");
      end
   endtask

   // Guard against a hang anywhere in the sequence
   initial begin
      cyc(60000);
      failures++;
      $display("CHECK FAILED at %0t: run too long", $time);
      end_of_test();
   end

   initial begin
      cyc(20);
      chk({errorLevel, resetPinOut, resetPinOeN, multiPinOeN, irq}, 5'b10010, "reset pin state");
      rstn <= 1'b1;
      rd_reg(OUT_CFG_OFS);
      chk(rdVal, 32'h0000002D, "out config reset");
      rd_reg(PIN_CTRL_OFS);
      chk(rdVal, 32'h00000000, "pin control reset");
      chk({resetPinOeN, resetPinPullup}, 2'b11, "idle reset pin");
      // Before configuration is read only enable may move
      setpin(1, 1'b0);
      cyc(1600);
      chk(errorLevel, 1'b1, "error input live too soon");
      filt(0, 1'b1, int'(EN_CYC), 0);
      configLoaded <= 1'b1;
      cyc(1520);
      chk(errorLevel, 1'b0, "error input not enabled");
      filt(1, 1'b1, int'(ERR_CYC), 1);
      filt(1, 1'b1, int'(ERR_CYC), 0);
      filt(0, 1'b0, int'(EN_CYC), 1);
      filt(0, 1'b0, int'(EN_CYC), 0);
      foreach (rows[k]) begin
         wr_reg(rows[k].a, rows[k].d);
         chk(resp, rows[k].r, "write response");
         rd_reg(rows[k].a);
         chk(resp, rows[k].r, "read response");
         chk(rdVal, rows[k].e, "read data");
      end
      filt(2, 1'b1, int'(MON_CYC3), 0);
      filt(3, 1'b1, int'(MON_CYC0), 0);
      wr_reg(PIN_CTRL_OFS, 32'h00000002);
      setpin(3, 1'b0);
      cyc(5);
      chk({syncClockOut, monitorTwoLevel}, 2'b00, "sync clock low");
      setpin(3, 1'b1);
      cyc(5);
      chk(syncClockOut, 1'b1, "sync clock high");
      wr_reg(PIN_CTRL_OFS, 32'h00000001);
      cyc(int'(WD_CYC) + 10);
      chk(watchdogDisable, 1'b1, "watchdog disable level");
      filt(5, 1'b0, int'(WD_CYC), 1);
      filt(5, 1'b0, int'(WD_CYC), 0);
      wr_reg(PIN_CTRL_OFS, 32'h00000000);
      cyc(int'(ADDR_CYC) + 10);
      chk(busAddrSel, 1'b1, "strap high address");
      filt(4, 1'b0, int'(ADDR_CYC), 0);
      // General output, open-drain active-low with pull-up from reset config
      wr_reg(PIN_CTRL_OFS, 32'h00000014);
      cyc(3);
      chk({multiPinOut, multiPinOeN, multiPinPullup, multiPinIn}, 4'b0000, "general out low");
      wr_reg(PIN_CTRL_OFS, 32'h00000004);
      cyc(3);
      chk({multiPinOut, multiPinOeN, multiPinPullup, multiPinIn}, 4'b0111, "general out high");
      for (int c = 0; c < 8; c++) begin
         wr_reg(OUT_CFG_OFS, 32'(c));
         for (int r = 0; r < 2; r++) begin
            coreResetReq <= r[0];
            cyc(3);
            lev = c[AH_BIT] ? r[0] : !r[0];
            exp3 = c[OD_BIT] ? {1'b0, lev, lev & c[PU_BIT]} : {lev, 2'b00};
            chk({resetPinOut, resetPinOeN, resetPinPullup}, exp3, "reset pin drive");
            chk(resetWire, c[OD_BIT] ? lev & c[PU_BIT] : lev, "reset line");
         end
      end
      // Interrupt on the multipurpose pin, push-pull active-high
      wr_reg(OUT_CFG_OFS, 32'h00000010);
      wr_reg(PIN_CTRL_OFS, 32'h00000008);
      wr_reg(EVT_CLR_OFS, 32'h0000001F);
      rd_reg(EVT_STAT_OFS);
      chk(rdVal, 32'h00000000, "status not cleared");
      filt(0, 1'b1, int'(EN_CYC), 0);
      rd_reg(EVT_STAT_OFS);
      chk(rdVal, 32'h00000001, "enable event");
      chk({irq, multiPinOut}, 2'b00, "masked event raised irq");
      wr_reg(EVT_EN_OFS, 32'h00000001);
      cyc(3);
      chk({irq, multiPinOut, multiPinOeN}, 3'b110, "irq not raised");
      // Lane 0 off: the write is answered but must not land
      s_axi_wstrb <= 4'hE;
      wr_reg(EVT_EN_OFS, 32'h00000000);
      s_axi_wstrb <= 4'hF;
      chk(resp, 2'h0, "masked write response");
      rd_reg(EVT_EN_OFS);
      chk(rdVal, 32'h00000001, "masked write landed");
      // Open-drain active-low interrupt pulls the line down
      wr_reg(OUT_CFG_OFS, 32'h00000008);
      cyc(3);
      chk({multiPinOut, multiPinOeN, multiPinIn}, 3'b000, "open-drain irq not low");
      wr_reg(OUT_CFG_OFS, 32'h00000010);
      wr_reg(EVT_CLR_OFS, 32'h00000001);
      cyc(3);
      chk({irq, multiPinOut}, 2'b00, "irq not cleared");
      coreIrqReq <= 1'b1;
      cyc(3);
      chk(multiPinOut, 1'b1, "core irq not shown");
      coreIrqReq <= 1'b0;
      // Supply loss gates every filter, enable included
      supplyValid <= 1'b0;
      cyc(3);
      chk({enableLevel, errorLevel}, 2'b01, "inputs live without supply");
      supplyValid <= 1'b1;
      // Reserved multipurpose code keeps the pin as an input
      wr_reg(PIN_CTRL_OFS, 32'h0000000C);
      cyc(3);
      chk(multiPinOeN, 1'b1, "reserved mode drives pin");
      rstn <= 1'b0;
      cyc(2);
      chk({errorLevel, resetPinOeN}, 2'b10, "second reset");
      rstn <= 1'b1;
      rd_reg(OUT_CFG_OFS);
      chk(rdVal, 32'h0000002D, "config after reset");
      end_of_test();
   end
endmodule
`default_nettype wire
